/* File: hw/bus_cycle_core.sv */
// 8-bit core: bus-cycle sequencer, addressing, flags and APB status port
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module bus_cycle_core
  import cpu_decode_pkg::*;
#(
  parameter logic [15:0] VECTOR_ADDR = SWI_VECTOR
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] sys_addr,
  output logic [7:0] sys_wdata,
  output logic sys_read,
  output logic [2:0] sys_kind,
  input wire logic [7:0] sys_rdata
);

  if (VECTOR_ADDR[15:8] != VECTOR_PAGE || VECTOR_ADDR[0] != 1'b0) begin : g_chk
    $error("VECTOR_ADDR must be an even address in the top page");
  end

  typedef enum logic [9:0] {
    S_FETCH = 10'b00_0000_0001,
    S_OPND = 10'b00_0000_0010,
    S_READ = 10'b00_0000_0100,
    S_WRITE = 10'b00_0000_1000,
    S_PUSH = 10'b00_0001_0000,
    S_PULL = 10'b00_0010_0000,
    S_VEC_HI = 10'b00_0100_0000,
    S_VEC_LO = 10'b00_1000_0000,
    S_REL = 10'b01_0000_0000,
    S_FREE = 10'b10_0000_0000
  } state_t;

  decode_if dif ();
  opcode_decoder u_dec (.dif(dif));

  state_t state_q, state_d, fin;
  logic run_q, prefix_q, eq_q;
  logic [15:0] pc_q, sp_q, ea_q, ea_calc, hx;
  logic [7:0] a_q, x_q, h_q, condition_flags_q, opnd_q, push_byte;
  logic [1:0] opnd_cnt_q, opnd_n_q;
  logic [3:0] cyc_q, cycles_q, goal, sel_q;
  logic [2:0] length_q, push_idx_q;
  op_class_t cls_q;
  addr_mode_t mode_q;
  logic [31:0] cycle_count_q, prdata_q, rd_mux;
  logic active, is_prefix, fetch_go, opnd_last, exec_alu, stay_prefix;
  logic apb_setup, apb_wr, mapped, halted;
  alu_out_t alu;

  function automatic logic is_store(logic [3:0] s);
    return s == SEL_STA || s == SEL_STX;
  endfunction : is_store

  function automatic logic [15:0] calc_ea(addr_mode_t m, logic [15:0] x,
                                          logic [15:0] sp, logic [15:0] w);
    case (m)
      DIRECT: return {DIRECT_PAGE, w[7:0]};
      EXTENDED: return w;
      INDEXED, INDEXED_POST_INCREMENT: return x;
      INDEXED_BYTE_OFFSET, INDEXED_BYTE_OFFSET_POST_INCREMENT,
      INDEXED_WORD_OFFSET: return x + w;
      STACK_BYTE_OFFSET, STACK_WORD_OFFSET: return sp + w;
      default: return w;
    endcase
  endfunction : calc_ea

  function automatic state_t dispatch(op_class_t c, logic [3:0] s,
                                      addr_mode_t m, state_t f);
    case (c)
      CLS_ALU: begin
        if (m == IMMEDIATE) begin
          return f;
        end
        return is_store(s) ? S_WRITE : S_READ;
      end
      CLS_CBEQ: return S_READ;
      CLS_PUSH, CLS_SWI: return S_PUSH;
      CLS_PULL: return S_PULL;
      default: return f;
    endcase
  endfunction : dispatch

  // Arithmetic and logic on one 8-bit operand with flag effects
  function automatic alu_out_t alu_f(logic [3:0] s, logic [7:0] a,
                                     logic [7:0] x, logic [7:0] m,
                                     logic [7:0] f);
    alu_out_t o;
    logic [8:0] t;
    logic [7:0] l;
    logic [8:0] cin;
    logic add, sub;
    o.res = 8'h00;
    o.wr_a = 1'b0;
    o.wr_x = 1'b0;
    o.flags = f;
    l = a;
    cin = {8'h00, f[FLAG_C]};
    add = 1'b0;
    sub = 1'b0;
    t = 9'h000;
    case (s)
      SEL_SUB, SEL_CMP, SEL_SBC: begin
        t = {1'b0, a} - {1'b0, m} - ((s == SEL_SBC) ? cin : 9'h000);
        sub = 1'b1;
        o.wr_a = (s != SEL_CMP);
      end
      SEL_CPX: begin
        t = {1'b0, x} - {1'b0, m};
        l = x;
        sub = 1'b1;
      end
      SEL_ADD, SEL_ADC: begin
        t = {1'b0, a} + {1'b0, m} + ((s == SEL_ADC) ? cin : 9'h000);
        add = 1'b1;
        o.wr_a = 1'b1;
      end
      SEL_AND, SEL_BIT: begin
        o.res = a & m;
        o.wr_a = (s == SEL_AND);
      end
      SEL_LDA: begin
        o.res = m;
        o.wr_a = 1'b1;
      end
      SEL_STA: o.res = a;
      SEL_EOR: begin
        o.res = a ^ m;
        o.wr_a = 1'b1;
      end
      SEL_ORA: begin
        o.res = a | m;
        o.wr_a = 1'b1;
      end
      SEL_LDX: begin
        o.res = m;
        o.wr_x = 1'b1;
      end
      SEL_STX: o.res = x;
      default: o.res = a;
    endcase
    if (add || sub) begin
      o.res = t[7:0];
      o.flags[FLAG_C] = t[8];
    end
    // Flags not named here are kept; logical ops clear overflow
    o.flags[FLAG_N] = o.res[7];
    o.flags[FLAG_Z] = (o.res == 8'h00);
    o.flags[FLAG_V] = 1'b0;
    if (sub) begin
      o.flags[FLAG_V] = (l[7] & ~m[7] & ~o.res[7]) | (~l[7] & m[7] & o.res[7]);
    end
    if (add) begin
      o.flags[FLAG_V] = (a[7] & m[7] & ~o.res[7]) | (~a[7] & ~m[7] & o.res[7]);
      o.flags[FLAG_H] = (a[3] & m[3]) | (m[3] & ~o.res[3]) |
                        (~o.res[3] & a[3]);
    end
    return o;
  endfunction : alu_f

  assign hx = {h_q, x_q};
  // An instruction already begun on its prefix finishes even if run drops
  assign active = run_q || prefix_q;
  assign halted = (state_q == S_FETCH) && !active;
  assign is_prefix = (state_q == S_FETCH) && active && !prefix_q &&
                     (sys_rdata == OPC_PREFIX);
  assign fetch_go = (state_q == S_FETCH) && active && !is_prefix;
  assign stay_prefix = is_prefix;
  assign opnd_last = (state_q == S_OPND) && (opnd_cnt_q == 2'd1);
  assign goal = (state_q == S_FETCH) ? dif.cycles : cycles_q;
  assign fin = (({1'b0, cyc_q} + 5'd1) < {1'b0, goal}) ? S_FREE : S_FETCH;
  assign exec_alu = (cls_q == CLS_ALU) &&
                    ((opnd_last && mode_q == IMMEDIATE) ||
                     state_q == S_READ || state_q == S_WRITE);
  assign alu = alu_f(sel_q, a_q, x_q, sys_rdata, condition_flags_q);
  assign ea_calc = calc_ea(mode_q, hx, sp_q, (opnd_n_q == 2'd2) ?
                           {opnd_q, sys_rdata} : {DIRECT_PAGE, sys_rdata});

  assign dif.prefix = prefix_q;
  assign dif.opcode = sys_rdata;

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_FETCH: begin
        if (fetch_go) begin
          if (dif.opnd_n != 2'd0) begin
            state_d = S_OPND;
          end else begin
            state_d = dispatch(dif.cls, dif.sel, dif.mode, fin);
          end
        end
      end
      S_OPND: begin
        if (opnd_last) begin
          state_d = dispatch(cls_q, sel_q, mode_q, fin);
        end
      end
      S_READ: state_d = (cls_q == CLS_CBEQ) ? S_REL : fin;
      S_PUSH: begin
        if (cls_q == CLS_SWI) begin
          state_d = (push_idx_q == SWI_LAST_PUSH) ? S_VEC_HI : S_PUSH;
        end else begin
          state_d = fin;
        end
      end
      S_VEC_HI: state_d = S_VEC_LO;
      S_WRITE, S_PULL, S_VEC_LO, S_REL, S_FREE: state_d = fin;
      default: state_d = S_FETCH;
    endcase
  end

  // Bus presentation of the current cycle
  always_comb begin
    sys_addr = pc_q;
    sys_wdata = 8'h00;
    sys_kind = CYC_FREE;
    case (state_q)
      S_FETCH, S_OPND, S_REL: begin
        sys_kind = halted ? CYC_FREE : CYC_PROGRAM;
      end
      S_READ: begin
        sys_addr = ea_q;
        sys_kind = CYC_READ;
      end
      S_WRITE: begin
        sys_addr = ea_q;
        sys_wdata = alu.res;
        sys_kind = CYC_WRITE;
      end
      S_PUSH: begin
        sys_addr = sp_q;
        sys_wdata = push_byte;
        sys_kind = CYC_PUSH;
      end
      S_PULL: begin
        sys_addr = sp_q + 16'h0001;
        sys_kind = CYC_POP;
      end
      S_VEC_HI: begin
        sys_addr = VECTOR_ADDR;
        sys_kind = CYC_VECTOR;
      end
      S_VEC_LO: begin
        sys_addr = VECTOR_ADDR | 16'h0001;
        sys_kind = CYC_VECTOR;
      end
      default: sys_kind = CYC_FREE;
    endcase
  end
  // Free cycles read so no stray write can reach memory
  assign sys_read = (sys_kind != CYC_WRITE) && (sys_kind != CYC_PUSH);

  always_comb begin
    case (push_idx_q)
      3'h0: push_byte = pc_q[7:0];
      3'h1: push_byte = pc_q[15:8];
      3'h2: push_byte = x_q;
      3'h3: push_byte = a_q;
      default: push_byte = condition_flags_q;
    endcase
    if (cls_q == CLS_PUSH) begin
      push_byte = a_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_FETCH;
      prefix_q <= 1'b0;
      cyc_q <= 4'h0;
    end else begin
      state_q <= state_d;
      if (is_prefix) begin
        prefix_q <= 1'b1;
      end else if (fetch_go) begin
        prefix_q <= 1'b0;
      end
      cyc_q <= (state_d == S_FETCH && !stay_prefix) ? 4'h0 : cyc_q + 4'h1;
    end
  end

  // Latched decode of the instruction in flight
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cls_q <= CLS_NOP;
      mode_q <= INHERENT;
      sel_q <= 4'h0;
      opnd_n_q <= 2'd0;
      length_q <= 3'd0;
      cycles_q <= 4'h0;
    end else if (fetch_go) begin
      cls_q <= dif.cls;
      mode_q <= dif.mode;
      sel_q <= dif.sel;
      opnd_n_q <= dif.opnd_n;
      length_q <= dif.length;
      cycles_q <= dif.cycles;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_q <= 8'h00;
      opnd_cnt_q <= 2'd0;
      ea_q <= 16'h0000;
      eq_q <= 1'b0;
      push_idx_q <= 3'h0;
    end else begin
      if (fetch_go) begin
        opnd_cnt_q <= dif.opnd_n;
        ea_q <= hx;
        push_idx_q <= 3'h0;
      end
      if (state_q == S_OPND) begin
        opnd_q <= sys_rdata;
        opnd_cnt_q <= opnd_cnt_q - 2'd1;
      end
      if (opnd_last) begin
        ea_q <= ea_calc;
      end
      if (state_q == S_READ) begin
        eq_q <= (a_q == sys_rdata);
      end
      if (state_q == S_PUSH) begin
        push_idx_q <= push_idx_q + 3'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= PC_RESET;
    end else if (halted && apb_wr && paddr == OFF_START_PC) begin
      pc_q <= pwdata[15:0];
    end else if (fetch_go && dif.cls == CLS_JMP && dif.mode == INDEXED) begin
      pc_q <= hx;
    end else if (opnd_last && cls_q == CLS_JMP) begin
      pc_q <= ea_calc;
    end else if (state_q == S_REL && eq_q) begin
      pc_q <= pc_q + 16'h0001 + {{8{sys_rdata[7]}}, sys_rdata};
    end else if (state_q == S_VEC_HI) begin
      pc_q[15:8] <= sys_rdata;
    end else if (state_q == S_VEC_LO) begin
      pc_q[7:0] <= sys_rdata;
    end else if ((state_q == S_FETCH && active) || state_q == S_OPND ||
                 state_q == S_REL) begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= STACK_RESET;
    end else if (state_q == S_PUSH) begin
      sp_q <= sp_q - 16'h0001;
    end else if (state_q == S_PULL) begin
      sp_q <= sp_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 8'h00;
      x_q <= 8'h00;
      h_q <= 8'h00;
      condition_flags_q <= FLAGS_RESET;
    end else begin
      if (exec_alu) begin
        condition_flags_q <= alu.flags;
        if (alu.wr_a) begin
          a_q <= alu.res;
        end
        if (alu.wr_x) begin
          x_q <= alu.res;
        end
      end
      if (state_q == S_PULL) begin
        a_q <= sys_rdata;
      end
      if (state_q == S_READ && cls_q == CLS_CBEQ) begin
        {h_q, x_q} <= hx + 16'h0001;
      end
      if (state_q == S_PUSH && push_idx_q == SWI_LAST_PUSH) begin
        condition_flags_q[FLAG_I] <= 1'b1;
      end
      if (fetch_go) begin
        case (dif.cls)
          CLS_SEI: condition_flags_q[FLAG_I] <= 1'b1;
          CLS_CLI: condition_flags_q[FLAG_I] <= 1'b0;
          CLS_SEC: condition_flags_q[FLAG_C] <= 1'b1;
          CLS_CLC: condition_flags_q[FLAG_C] <= 1'b0;
          default: condition_flags_q <= condition_flags_q;
        endcase
      end
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && mapped;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_START_PC) ||
                  (paddr == OFF_CORE_STATE) ||
                  (paddr == OFF_STACK_DECODE) || (paddr == OFF_CYCLE_COUNT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  always_comb begin
    case (paddr)
      OFF_CTRL: rd_mux = {31'h0000_0000, run_q};
      OFF_START_PC: rd_mux = {16'h0000, pc_q};
      OFF_CORE_STATE: rd_mux = {condition_flags_q, h_q, x_q, a_q};
      OFF_STACK_DECODE: rd_mux = {8'h00, cycles_q, 1'b0, length_q, sp_q};
      OFF_CYCLE_COUNT: rd_mux = cycle_count_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      run_q <= 1'b0;
      cycle_count_q <= 32'h0000_0000;
    end else begin
      if (apb_setup) begin
        prdata_q <= rd_mux;
      end
      if (apb_wr && paddr == OFF_CTRL) begin
        run_q <= pwdata[CTRL_RUN_BIT];
      end
      if (!halted) begin
        cycle_count_q <= cycle_count_q + 32'h0000_0001;
      end
    end
  end

endmodule : bus_cycle_core

/* File: hw/cpu_decode_pkg.sv */
// Shared constants and types for the 8-bit core and its opcode decoder
package cpu_decode_pkg;

  // Register map, byte addresses on the APB side
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_START_PC = 12'h004;
  localparam logic [11:0] OFF_CORE_STATE = 12'h008;
  localparam logic [11:0] OFF_STACK_DECODE = 12'h00c;
  localparam logic [11:0] OFF_CYCLE_COUNT = 12'h010;
  localparam int unsigned CTRL_RUN_BIT = 0;

  // Core constants
  localparam logic [7:0] OPC_PREFIX = 8'h9e;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam logic [7:0] VECTOR_PAGE = 8'hff;
  localparam logic [15:0] STACK_RESET = 16'h00ff;
  localparam logic [15:0] SWI_VECTOR = 16'hfffc;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [2:0] SWI_LAST_PUSH = 3'h4;

  // condition_flags layout: V 1 1 H I N Z C
  localparam int unsigned FLAG_V = 7;
  localparam int unsigned FLAG_H = 4;
  localparam int unsigned FLAG_I = 3;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_C = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h68;

  // Low nibble of register/memory opcodes selects the operation
  localparam logic [3:0] SEL_SUB = 4'h0;
  localparam logic [3:0] SEL_CMP = 4'h1;
  localparam logic [3:0] SEL_SBC = 4'h2;
  localparam logic [3:0] SEL_CPX = 4'h3;
  localparam logic [3:0] SEL_AND = 4'h4;
  localparam logic [3:0] SEL_BIT = 4'h5;
  localparam logic [3:0] SEL_LDA = 4'h6;
  localparam logic [3:0] SEL_STA = 4'h7;
  localparam logic [3:0] SEL_EOR = 4'h8;
  localparam logic [3:0] SEL_ADC = 4'h9;
  localparam logic [3:0] SEL_ORA = 4'ha;
  localparam logic [3:0] SEL_ADD = 4'hb;
  localparam logic [3:0] SEL_JMP = 4'hc;
  localparam logic [3:0] SEL_JSR = 4'hd;
  localparam logic [3:0] SEL_LDX = 4'he;
  localparam logic [3:0] SEL_STX = 4'hf;

  typedef enum logic [2:0] {
    CYC_FREE = 3'h0,
    CYC_PROGRAM = 3'h1,
    CYC_READ = 3'h2,
    CYC_WRITE = 3'h3,
    CYC_PUSH = 3'h4,
    CYC_POP = 3'h5,
    CYC_VECTOR = 3'h6
  } bus_cycle_t;

  typedef enum logic [3:0] {
    INHERENT = 4'h0,
    IMMEDIATE = 4'h1,
    DIRECT = 4'h2,
    EXTENDED = 4'h3,
    INDEXED = 4'h4,
    INDEXED_BYTE_OFFSET = 4'h5,
    INDEXED_WORD_OFFSET = 4'h6,
    INDEXED_POST_INCREMENT = 4'h7,
    INDEXED_BYTE_OFFSET_POST_INCREMENT = 4'h8,
    STACK_BYTE_OFFSET = 4'h9,
    STACK_WORD_OFFSET = 4'ha
  } addr_mode_t;

  typedef enum logic [3:0] {
    CLS_NOP = 4'h0,
    CLS_ALU = 4'h1,
    CLS_JMP = 4'h2,
    CLS_CBEQ = 4'h3,
    CLS_PUSH = 4'h4,
    CLS_PULL = 4'h5,
    CLS_SWI = 4'h6,
    CLS_SEI = 4'h7,
    CLS_CLI = 4'h8,
    CLS_SEC = 4'h9,
    CLS_CLC = 4'ha
  } op_class_t;

  typedef struct packed {
    logic [7:0] res;
    logic wr_a;
    logic wr_x;
    logic [7:0] flags;
  } alu_out_t;

endpackage : cpu_decode_pkg

/* File: hw/decode_if.sv */
// Carrier between the sequencer and the opcode decoder
`timescale 1ns/1ps
interface decode_if;
  import cpu_decode_pkg::*;
  logic prefix;
  logic [7:0] opcode;
  op_class_t cls;
  addr_mode_t mode;
  logic [3:0] sel;
  logic [1:0] opnd_n;
  logic [2:0] length;
  logic [3:0] cycles;
  modport core (output prefix, output opcode, input cls, input mode,
                input sel, input opnd_n, input length, input cycles);
  modport dec (input prefix, input opcode, output cls, output mode,
               output sel, output opnd_n, output length, output cycles);
endinterface : decode_if

/* File: hw/opcode_decoder.sv */
// Opcode decoder: class, addressing mode, length and cycle count
`timescale 1ns/1ps
module opcode_decoder
  import cpu_decode_pkg::*;
(
  decode_if.dec dif
);
  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = dif.opcode[7:4];
  assign lo = dif.opcode[3:0];

  always_comb begin
    dif.cls = CLS_NOP;
    dif.mode = INHERENT;
    dif.sel = lo;
    dif.opnd_n = 2'd0;
    dif.length = 3'd1;
    dif.cycles = 4'd1;
    if (dif.prefix) begin
      // Second page: only the stack-offset register/memory forms
      dif.length = 3'd2;
      if (hi == 4'he || hi == 4'hd) begin
        dif.cls = (lo == SEL_JMP || lo == SEL_JSR) ? CLS_NOP : CLS_ALU;
        dif.mode = (hi == 4'he) ? STACK_BYTE_OFFSET : STACK_WORD_OFFSET;
        dif.opnd_n = (hi == 4'he) ? 2'd1 : 2'd2;
        dif.length = (hi == 4'he) ? 3'd3 : 3'd4;
        dif.cycles = (hi == 4'he) ? 4'd4 : 4'd5;
      end
    end else begin
      case (dif.opcode)
        8'h71: begin
          dif.cls = CLS_CBEQ;
          dif.mode = INDEXED_POST_INCREMENT;
          dif.length = 3'd2;
          dif.cycles = 4'd5;
        end
        8'h61: begin
          dif.cls = CLS_CBEQ;
          dif.mode = INDEXED_BYTE_OFFSET_POST_INCREMENT;
          dif.opnd_n = 2'd1;
          dif.length = 3'd3;
          dif.cycles = 4'd5;
        end
        8'h87: begin
          dif.cls = CLS_PUSH;
          dif.cycles = 4'd2;
        end
        8'h86: begin
          dif.cls = CLS_PULL;
          dif.cycles = 4'd3;
        end
        8'h83: begin
          dif.cls = CLS_SWI;
          dif.cycles = 4'd11;
        end
        8'h9b: dif.cls = CLS_SEI;
        8'h9a: dif.cls = CLS_CLI;
        8'h99: dif.cls = CLS_SEC;
        8'h98: dif.cls = CLS_CLC;
        default: begin
          if (hi >= 4'ha) begin
            dif.cls = (lo == SEL_JMP) ? CLS_JMP : CLS_ALU;
            if (lo == SEL_JSR) begin
              dif.cls = CLS_NOP;
            end
            case (hi)
              4'ha: begin
                dif.mode = IMMEDIATE;
                dif.opnd_n = 2'd1;
                dif.length = 3'd2;
                dif.cycles = 4'd2;
                if (lo == SEL_STA || lo == SEL_STX || lo == SEL_JMP) begin
                  dif.cls = CLS_NOP;
                end
              end
              4'hb: begin
                dif.mode = DIRECT;
                dif.opnd_n = 2'd1;
                dif.length = 3'd2;
                dif.cycles = 4'd3;
              end
              4'hc: begin
                dif.mode = EXTENDED;
                dif.opnd_n = 2'd2;
                dif.length = 3'd3;
                dif.cycles = 4'd4;
              end
              4'hd: begin
                dif.mode = INDEXED_WORD_OFFSET;
                dif.opnd_n = 2'd2;
                dif.length = 3'd3;
                dif.cycles = 4'd4;
              end
              4'he: begin
                dif.mode = INDEXED_BYTE_OFFSET;
                dif.opnd_n = 2'd1;
                dif.length = 3'd2;
                dif.cycles = 4'd3;
              end
              default: begin
                dif.mode = INDEXED;
                dif.cycles = (lo == SEL_STA || lo == SEL_STX) ? 4'd2 : 4'd3;
              end
            endcase
          end
        end
      endcase
    end
  end
endmodule : opcode_decoder

/* File: verification/bus_cycle_core_properties.sv */
// Checker for the system bus cycle kinds of the core
`timescale 1ns/1ps
module bus_cycle_core_properties
  import cpu_decode_pkg::*;
#(
  parameter logic [15:0] VECTOR_ADDR = SWI_VECTOR
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] sys_addr,
  input wire logic [7:0] sys_wdata,
  input wire logic sys_read,
  input wire logic [2:0] sys_kind
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence vec_hi;
    sys_kind == CYC_VECTOR && sys_addr == VECTOR_ADDR;
  endsequence
  sequence vec_lo;
    sys_kind == CYC_VECTOR && sys_addr == VECTOR_ADDR + 16'h0001;
  endsequence
  vector_order_a: assert property (vec_hi |=> vec_lo)
    else $error("vector low byte not after high byte");
  vector_page_a: assert property (sys_kind == CYC_VECTOR |->
    sys_addr[15:8] == VECTOR_PAGE) else $error("vector off top page");
  free_read_a: assert property (sys_kind == CYC_FREE |-> sys_read)
    else $error("free cycle not a read");
  fetch_step_a: assert property (sys_kind == CYC_PROGRAM ##1
    sys_kind == CYC_PROGRAM |-> sys_addr == $past(sys_addr) + 16'h0001)
    else $error("fetch address did not step by one");
  push_write_a: assert property (sys_kind == CYC_PUSH |-> !sys_read)
    else $error("push not a write");
  push_step_a: assert property (sys_kind == CYC_PUSH ##1
    sys_kind == CYC_PUSH |-> sys_addr == $past(sys_addr) - 16'h0001)
    else $error("push address did not step down");
  pop_read_a: assert property (sys_kind == CYC_POP |-> sys_read)
    else $error("pop not a read");
  operand_write_a: assert property (sys_kind == CYC_WRITE |-> !sys_read)
    else $error("operand write shown as read");
  idle_data_a: assert property (sys_read |-> sys_wdata == 8'h00)
    else $error("write data driven in a read");
endmodule : bus_cycle_core_properties
bind bus_cycle_core bus_cycle_core_properties #(.VECTOR_ADDR(VECTOR_ADDR))
  chk_u (.pclk(pclk), .presetn(presetn), .sys_addr(sys_addr),
  .sys_wdata(sys_wdata), .sys_read(sys_read), .sys_kind(sys_kind));

/* File: verification/sys_memory_model.sv */
// Flat memory answering the core's system bus with no wait states
`timescale 1ns/1ps
module sys_memory_model (
  input wire logic pclk,
  input wire logic [15:0] sys_addr,
  input wire logic [7:0] sys_wdata,
  input wire logic [2:0] sys_kind,
  output logic [7:0] sys_rdata
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  end
  // Only operand writes and pushes store, one byte per cycle
  always @(posedge pclk) begin
    if (sys_kind == 3'h3 || sys_kind == 3'h4) begin
      mem[sys_addr] <= sys_wdata;
    end
  end
  assign sys_rdata = mem[sys_addr];
endmodule : sys_memory_model

/* File: verification/cpu_bus_cycle_and_addressing_decode_test.sv */
// Bench: runs two short programs and checks bus cycles and registers
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module cpu_bus_cycle_and_addressing_decode_test;
  import cpu_decode_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, sys_read;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] sys_addr;
  logic [7:0] sys_wdata, sys_rdata;
  logic [2:0] sys_kind;
  int err_count = 0;
  int checks_done = 0;
  logic [18:0] log_q [$];
  // Kind and address of every read, write, push, pop and vector cycle both programs make
  logic [18:0] exp_q [$] = '{19'h2_0200, 19'h4_00ff, 19'h5_00ff,
    19'h2_0010, 19'h2_0101, 19'h2_0100, 19'h3_0000, 19'h2_0000,
    19'h2_0002, 19'h4_00ff, 19'h4_00fe, 19'h4_00fd, 19'h4_00fc,
    19'h4_00fb, 19'h6_fffc, 19'h6_fffd, 19'h2_0101, 19'h3_0020,
    19'h2_0010};
  logic [7:0] prog [0:20] = '{8'hc6, 8'h02, 8'h00, 8'h87, 8'h86, 8'he6,
    8'h10, 8'h9e, 8'he6, 8'h02, 8'h9e, 8'hd6, 8'h00, 8'h01, 8'hf7, 8'h71,
    8'h00, 8'h61, 8'h01, 8'h00, 8'h83};
  // Second run: immediate, word-offset, direct, no-offset, flag opcodes
  logic [7:0] prog2 [0:14] = '{8'hae, 8'h10, 8'hd6, 8'h00, 8'hf1, 8'hab,
    8'h7f, 8'hb7, 8'h20, 8'hf6, 8'h99, 8'h9a, 8'hcc, 8'h04, 8'h0c};
  bus_cycle_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_read(sys_read),
    .sys_kind(sys_kind), .sys_rdata(sys_rdata));
  sys_memory_model mem_u (.pclk(pclk), .sys_addr(sys_addr),
    .sys_wdata(sys_wdata), .sys_kind(sys_kind), .sys_rdata(sys_rdata));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (presetn && sys_kind >= 3'h2) log_q.push_back({sys_kind, sys_addr});
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Runs from from_pc until the core loops at loop_pc, then halts it there
  task automatic run_until(input logic [15:0] from_pc,
                           input logic [15:0] loop_pc);
    apb(1'b1, OFF_START_PC, {16'h0000, from_pc});
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    for (int i = 0; i < 300 && sys_addr !== loop_pc; i++) @(posedge pclk);
    `CHK(sys_addr, loop_pc)
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    for (int i = 0; i < 20 && sys_kind !== 3'h0; i++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    `CHK({sys_kind, sys_read, sys_addr}, {3'h0, 1'b1, loop_pc})
  endtask : run_until
  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    #60000;
    err_count++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 21; i++) mem_u.mem[16'h0100 + i] = prog[i];
    for (int i = 0; i < 15; i++) mem_u.mem[16'h0400 + i] = prog2[i];
    mem_u.mem[16'h0200] = 8'hc3;
    mem_u.mem[16'hfffc] = 8'h03;
    mem_u.mem[16'h0300] = 8'hcc;
    mem_u.mem[16'h0301] = 8'h03;
    apb(1'b0, OFF_CORE_STATE, 32'h0000_0000);
    `CHK({er, rd}, {1'b0, 32'h6800_0000})
    apb(1'b0, 12'h014, 32'h0000_0000);
    `CHK({er, rd}, {1'b1, 32'h0000_0000})
    run_until(16'h0100, 16'h0300);
    apb(1'b0, OFF_START_PC, 32'h0000_0000);
    `CHK(rd[15:0], 16'h0300)
    apb(1'b0, OFF_CORE_STATE, 32'h0000_0000);
    `CHK(rd, 32'h6c00_02c6)
    apb(1'b0, OFF_STACK_DECODE, 32'h0000_0000);
    `CHK(rd[23:0], 24'h43_00fa)
    run_until(16'h0400, 16'h040c);
    apb(1'b0, OFF_CORE_STATE, 32'h0000_0000);
    `CHK(rd, 32'h7300_1000)
    apb(1'b0, OFF_CTRL, 32'h0000_0000);
    `CHK({er, rd}, {1'b0, 32'h0000_0000})
    `CHK(log_q.size(), exp_q.size())
    foreach (exp_q[i]) `CHK(log_q[i], exp_q[i])
    `CHK({mem_u.mem[0], mem_u.mem[16'h00fb], mem_u.mem[16'h00ff],
         mem_u.mem[16'h0020]}, 32'hc66c_1581)
    end_of_test();
  end
endmodule : cpu_bus_cycle_and_addressing_decode_test
